// ===== rtl/uart_rx_core.sv
// Serial receiver with overrun handling, node address filter and baud divisor
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ps
module uart_rx_core
(
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_sys_rst,
  // Wishbone slave
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [11:0] i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  // Serial line
  input  wire logic        i_rx_line,
  // Interrupt
  output logic             o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [1:0]  line_sync_q, line_sync_d;
  logic [7:0]  node_q, node_d, baud_hi_q, baud_hi_d, baud_lo_q, baud_lo_d;
  logic [7:0]  ctrl_q, ctrl_d, shift_q, shift_d, data_q, data_d, status;
  logic [3:0]  irq_stat_q, irq_stat_d, irq_mask_q, irq_mask_d, ev;
  logic [3:0]  os_q, os_d, bit_q, bit_d;
  logic [31:0] rdata_q, rdata_d;
  logic [15:0] div_cnt_q, div_cnt_d;
  uart_rx_pkg::rx_state_t state_q, state_d;
  logic        ack_q, ack_d, all_zero_q, all_zero_d, avail_q, avail_d;
  logic        ovr_pend_q, ovr_pend_d, brk_pend_q, brk_pend_d;
  logic        ovr_show_q, ovr_show_d, brk_show_q, brk_show_d;
  logic        frame_q, frame_d, addr_flag_q, addr_flag_d, matched_q, matched_d;
  logic        line_s, tick, wr_acc, rd_acc, rd_data;
  logic        done, done_addr, stop_ok, is_break, accept;

  // Byte lane write merge, lane chosen by the low address bits
  function automatic logic [7:0] lane_wr(input logic [7:0]  cur,
                                         input logic [11:0] adr,
                                         input logic [3:0]  sel,
                                         input logic [31:0] dat);
    logic [1:0] ln;
    ln = adr[1:0];
    lane_wr = sel[ln] ? dat[8*ln +: 8] : cur;
  endfunction

  // Place a byte in its lane for reads
  function automatic logic [31:0] lane_rd(input logic [11:0] adr,
                                          input logic [7:0]  val);
    lane_rd = {24'h000000, val} << (8 * adr[1:0]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Line synchroniser and baud tick

  // Divisor of zero is treated as one so the tick never stalls
  always_comb
  begin
    line_sync_d = {line_sync_q[0], i_rx_line};
    line_s      = line_sync_q[1];
    tick      = 1'b0;
    div_cnt_d = div_cnt_q + 16'h0001;
    if (div_cnt_q + 16'h0001 >= {baud_hi_q, baud_lo_q})
    begin
      tick      = 1'b1;
      div_cnt_d = 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  always_comb
  begin
    wr_acc  = i_wb_cyc && i_wb_stb && i_wb_we && !ack_q;
    rd_acc  = i_wb_cyc && i_wb_stb && !i_wb_we && !ack_q;
    rd_data = rd_acc && (i_wb_adr == uart_rx_pkg::ADDR_DATA);
    ack_d   = i_wb_cyc && i_wb_stb && !ack_q;
    status  = 8'h00;
    status[uart_rx_pkg::ST_DATA_AVAIL] = avail_q;
    status[uart_rx_pkg::ST_OVERRUN]    = ovr_show_q;
    status[uart_rx_pkg::ST_FRAMING]    = frame_q;
    status[uart_rx_pkg::ST_BREAK]      = brk_show_q;
    status[uart_rx_pkg::ST_ADDR_BYTE]  = addr_flag_q;
    rdata_d = 32'h00000000;
    if (rd_acc)
    begin
      if (i_wb_adr == uart_rx_pkg::ADDR_NODE)
        rdata_d = lane_rd(i_wb_adr, node_q);
      else if (i_wb_adr == uart_rx_pkg::ADDR_BAUD_HIGH)
        rdata_d = lane_rd(i_wb_adr, baud_hi_q);
      else if (i_wb_adr == uart_rx_pkg::ADDR_BAUD_LOW)
        rdata_d = lane_rd(i_wb_adr, baud_lo_q);
      else if (i_wb_adr == uart_rx_pkg::ADDR_DATA)
        rdata_d = {24'h000000, data_q};
      else if (i_wb_adr == uart_rx_pkg::ADDR_STATUS)
        rdata_d = {24'h000000, status};
      else if (i_wb_adr == uart_rx_pkg::ADDR_CTRL)
        rdata_d = {24'h000000, ctrl_q};
      else if (i_wb_adr == uart_rx_pkg::ADDR_IRQ_STAT)
        rdata_d = {28'h0000000, irq_stat_q};
      else if (i_wb_adr == uart_rx_pkg::ADDR_IRQ_MASK)
        rdata_d = {28'h0000000, irq_mask_q};
    end
  end

  always_comb
  begin
    node_d     = node_q;
    baud_hi_d  = baud_hi_q;
    baud_lo_d  = baud_lo_q;
    ctrl_d     = ctrl_q;
    irq_mask_d = irq_mask_q;
    if (wr_acc)
    begin
      if (i_wb_adr == uart_rx_pkg::ADDR_NODE)
        node_d = lane_wr(node_q, i_wb_adr, i_wb_sel, i_wb_dat);
      else if (i_wb_adr == uart_rx_pkg::ADDR_BAUD_HIGH)
        baud_hi_d = lane_wr(baud_hi_q, i_wb_adr, i_wb_sel, i_wb_dat);
      else if (i_wb_adr == uart_rx_pkg::ADDR_BAUD_LOW)
        baud_lo_d = lane_wr(baud_lo_q, i_wb_adr, i_wb_sel, i_wb_dat);
      else if (i_wb_adr == uart_rx_pkg::ADDR_CTRL && i_wb_sel[0])
        ctrl_d = i_wb_dat[7:0];
      else if (i_wb_adr == uart_rx_pkg::ADDR_IRQ_MASK && i_wb_sel[0])
        irq_mask_d = i_wb_dat[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive state machine: 8 data bits, one address/data marker bit when
  // multiprocessor operation is on, one stop bit

  always_comb
  begin
    state_d    = state_q;
    os_d       = os_q;
    bit_d      = bit_q;
    shift_d    = shift_q;
    all_zero_d = all_zero_q;
    done       = 1'b0;
    done_addr  = 1'b0;
    stop_ok    = 1'b0;
    case (state_q)
      uart_rx_pkg::RX_IDLE:
        if (ctrl_q[uart_rx_pkg::CT_RX_ENABLE] && !line_s)
        begin
          state_d    = uart_rx_pkg::RX_START;
          os_d       = 4'h0;
          all_zero_d = 1'b1;
        end
      uart_rx_pkg::RX_START:
        if (tick)
        begin
          os_d = os_q + 4'h1;
          if (os_q == uart_rx_pkg::OVERSAMPLE_MID && line_s)
            state_d = uart_rx_pkg::RX_IDLE;
          else if (os_q == uart_rx_pkg::OVERSAMPLE_LAST)
          begin
            state_d = uart_rx_pkg::RX_DATA;
            bit_d   = 4'h0;
          end
        end
      uart_rx_pkg::RX_DATA:
        if (tick)
        begin
          os_d = os_q + 4'h1;
          if (os_q == uart_rx_pkg::OVERSAMPLE_MID)
          begin
            shift_d    = {line_s, shift_q[7:1]};
            all_zero_d = all_zero_q && !line_s;
          end
          if (os_q == uart_rx_pkg::OVERSAMPLE_LAST)
          begin
            bit_d = bit_q + 4'h1;
            if (bit_q == uart_rx_pkg::DATA_BITS_LAST)
              state_d = ctrl_q[uart_rx_pkg::CT_MP_ENABLE] ?
                        uart_rx_pkg::RX_ADDR : uart_rx_pkg::RX_STOP;
          end
        end
      uart_rx_pkg::RX_ADDR:
        if (tick)
        begin
          os_d = os_q + 4'h1;
          if (os_q == uart_rx_pkg::OVERSAMPLE_MID)
            bit_d = {3'b000, line_s};
          if (os_q == uart_rx_pkg::OVERSAMPLE_LAST)
            state_d = uart_rx_pkg::RX_STOP;
        end
      uart_rx_pkg::RX_STOP:
        // Low stop: wait for idle, else its tail would pass for a new start bit
        if (os_q == uart_rx_pkg::OVERSAMPLE_LAST)
          state_d = line_s ? uart_rx_pkg::RX_IDLE : uart_rx_pkg::RX_STOP;
        else if (tick && os_q == uart_rx_pkg::OVERSAMPLE_MID)
        begin
          done      = 1'b1;
          stop_ok   = line_s;
          done_addr = ctrl_q[uart_rx_pkg::CT_MP_ENABLE] && bit_q[0];
          state_d   = line_s ? uart_rx_pkg::RX_IDLE : uart_rx_pkg::RX_STOP;
          os_d      = line_s ? 4'h0 : uart_rx_pkg::OVERSAMPLE_LAST;
        end
        else if (tick)
          os_d = os_q + 4'h1;
      default:
        state_d = uart_rx_pkg::RX_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Character acceptance, overrun and error flags

  always_comb
  begin
    is_break    = done && !stop_ok && all_zero_q;
    data_d      = data_q;
    avail_d     = avail_q;
    ovr_pend_d  = ovr_pend_q;
    brk_pend_d  = brk_pend_q;
    ovr_show_d  = ovr_show_q;
    brk_show_d  = brk_show_q;
    frame_d     = frame_q;
    addr_flag_d = addr_flag_q;
    matched_d   = matched_q;
    accept      = 1'b0;
    ev          = 4'h0;
    // Host read of the data register: reveal pending errors, or clear shown ones when an overrun is shown
    if (rd_data)
    begin
      avail_d = 1'b0;
      if (ovr_show_q)
      begin
        ovr_show_d = 1'b0;
        brk_show_d = 1'b0;
        frame_d    = 1'b0;
      end
      else if (ovr_pend_q)
      begin
        ovr_show_d = 1'b1;
        brk_show_d = brk_pend_q;
        ovr_pend_d = 1'b0;
        brk_pend_d = 1'b0;
        avail_d    = 1'b1;
      end
    end
    if (done)
    begin
      if (done_addr && ctrl_q[uart_rx_pkg::CT_MP_MODE1])
        matched_d = (shift_q == node_q);
      accept = !(ctrl_q[uart_rx_pkg::CT_MP_ENABLE] && ctrl_q[uart_rx_pkg::CT_MP_MODE1]) ||
               (done_addr ? (shift_q == node_q) : matched_q);
      if (!stop_ok)
      begin
        frame_d = 1'b1;
        ev[uart_rx_pkg::IRQ_FRAMING] = 1'b1;
      end
      if (is_break)
        ev[uart_rx_pkg::IRQ_BREAK] = 1'b1;
      if (accept && avail_q && !rd_data)
      begin
        ovr_pend_d = 1'b1;
        brk_pend_d = brk_pend_q || is_break;
        ev[uart_rx_pkg::IRQ_OVERRUN] = 1'b1;
      end
      else if (accept)
      begin
        data_d      = shift_q;
        avail_d     = 1'b1;
        addr_flag_d = done_addr;
        ev[uart_rx_pkg::IRQ_DATA] = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky interrupt status, write one to clear, set wins

  always_comb
  begin
    irq_stat_d = irq_stat_q;
    if (wr_acc && i_wb_adr == uart_rx_pkg::ADDR_IRQ_STAT && i_wb_sel[0])
      irq_stat_d = irq_stat_q & ~i_wb_dat[3:0];
    irq_stat_d = irq_stat_d | ev;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      line_sync_q <= 2'b11;
      node_q      <= uart_rx_pkg::RST_NODE;
      baud_hi_q   <= uart_rx_pkg::RST_BAUD_HIGH;
      baud_lo_q   <= uart_rx_pkg::RST_BAUD_LOW;
      ctrl_q      <= uart_rx_pkg::RST_CTRL;
      irq_stat_q  <= 4'h0;
      irq_mask_q  <= uart_rx_pkg::RST_IRQ_MASK;
      rdata_q     <= 32'h00000000;
      ack_q       <= 1'b0;
      div_cnt_q   <= 16'h0000;
      state_q     <= uart_rx_pkg::RX_IDLE;
      os_q        <= 4'h0;
      bit_q       <= 4'h0;
      shift_q     <= 8'h00;
      all_zero_q  <= 1'b0;
      data_q      <= 8'h00;
      avail_q     <= 1'b0;
      ovr_pend_q  <= 1'b0;
      brk_pend_q  <= 1'b0;
      ovr_show_q  <= 1'b0;
      brk_show_q  <= 1'b0;
      frame_q     <= 1'b0;
      addr_flag_q <= 1'b0;
      matched_q   <= 1'b0;
    end
    else
    begin
      line_sync_q <= line_sync_d;
      node_q      <= node_d;
      baud_hi_q   <= baud_hi_d;
      baud_lo_q   <= baud_lo_d;
      ctrl_q      <= ctrl_d;
      irq_stat_q  <= irq_stat_d;
      irq_mask_q  <= irq_mask_d;
      rdata_q     <= rdata_d;
      ack_q       <= ack_d;
      div_cnt_q   <= div_cnt_d;
      state_q     <= state_d;
      os_q        <= os_d;
      bit_q       <= bit_d;
      shift_q     <= shift_d;
      all_zero_q  <= all_zero_d;
      data_q      <= data_d;
      avail_q     <= avail_d;
      ovr_pend_q  <= ovr_pend_d;
      brk_pend_q  <= brk_pend_d;
      ovr_show_q  <= ovr_show_d;
      brk_show_q  <= brk_show_d;
      frame_q     <= frame_d;
      addr_flag_q <= addr_flag_d;
      matched_q   <= matched_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  always_comb
  begin
    o_wb_dat = rdata_q;
    o_wb_ack = ack_q;
    o_irq    = |(irq_stat_q & irq_mask_q);
  end

endmodule

// ===== rtl/uart_rx_pkg.sv
// Package: register map, field positions, reset values and timing for the serial receiver
package uart_rx_pkg;
  // Register byte addresses on the Wishbone bus
  localparam logic [11:0] ADDR_NODE      = 12'hf45;
  localparam logic [11:0] ADDR_BAUD_HIGH = 12'hf46;
  localparam logic [11:0] ADDR_BAUD_LOW  = 12'hf47;
  localparam logic [11:0] ADDR_DATA      = 12'hf48;
  localparam logic [11:0] ADDR_STATUS    = 12'hf4c;
  localparam logic [11:0] ADDR_CTRL      = 12'hf50;
  localparam logic [11:0] ADDR_IRQ_STAT  = 12'hf54;
  localparam logic [11:0] ADDR_IRQ_MASK  = 12'hf58;
  // Reset values
  localparam logic [7:0] RST_NODE      = 8'h00;
  localparam logic [7:0] RST_BAUD_HIGH = 8'hff;
  localparam logic [7:0] RST_BAUD_LOW  = 8'hff;
  localparam logic [7:0] RST_CTRL      = 8'h00;
  localparam logic [3:0] RST_IRQ_MASK  = 4'h0;
  // Status register bit positions
  localparam int ST_DATA_AVAIL = 0;
  localparam int ST_OVERRUN    = 1;
  localparam int ST_FRAMING    = 2;
  localparam int ST_BREAK      = 3;
  localparam int ST_ADDR_BYTE  = 4;
  // Control register bit positions
  localparam int CT_RX_ENABLE  = 0;
  localparam int CT_MP_ENABLE  = 1;
  localparam int CT_MP_MODE0   = 2;
  localparam int CT_MP_MODE1   = 3;
  // Interrupt status and mask bit positions
  localparam int IRQ_DATA      = 0;
  localparam int IRQ_BREAK     = 1;
  localparam int IRQ_OVERRUN   = 2;
  localparam int IRQ_FRAMING   = 3;
  // Oversampling: sixteen divisor ticks per bit, sample at the middle
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;
  localparam logic [3:0] OVERSAMPLE_MID  = 4'h7;
  localparam logic [3:0] DATA_BITS_LAST  = 4'h7;
  // Receiver states, Gray coded from RX_IDLE through RX_START, RX_DATA and RX_ADDR to RX_STOP
  typedef enum logic [2:0] {
    RX_IDLE   = 3'b000,
    RX_START  = 3'b001,
    RX_DATA   = 3'b011,
    RX_ADDR   = 3'b010,
    RX_STOP   = 3'b110
  } rx_state_t;
endpackage

// ===== dv/uart_rx_core_asserts.sv
// Checker of bus, register and interrupt relations at the receiver ports
`timescale 1ns/1ps
module uart_rx_core_asserts
(
  // Clock and reset
  input wire logic        i_ref_clk,
  input wire logic        i_sys_rst,
  // Wishbone slave
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic        i_wb_we,
  input wire logic [11:0] i_wb_adr,
  input wire logic [3:0]  i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic        o_wb_ack,
  // Serial line and interrupt
  input wire logic        i_rx_line,
  input wire logic        o_irq
);
  logic        take;
  logic        wr;
  logic [11:0] adr_q, adr_d;
  logic        rd_q, rd_d;
  logic [7:0]  node_q, node_d, bh_q, bh_d, bl_q, bl_d;
  logic [3:0]  mask_q, mask_d;
  // Shadow copies of the node, divisor and mask registers, updated at the taking edge
  always_comb
  begin
    take   = i_wb_cyc && i_wb_stb && !o_wb_ack;
    wr     = take && i_wb_we;
    adr_d  = take ? i_wb_adr : adr_q;
    rd_d   = take ? !i_wb_we : rd_q;
    node_d = (wr && i_wb_adr == uart_rx_pkg::ADDR_NODE && i_wb_sel[1]) ? i_wb_dat[15:8] : node_q;
    bh_d   = (wr && i_wb_adr == uart_rx_pkg::ADDR_BAUD_HIGH && i_wb_sel[2]) ? i_wb_dat[23:16] : bh_q;
    bl_d   = (wr && i_wb_adr == uart_rx_pkg::ADDR_BAUD_LOW && i_wb_sel[3]) ? i_wb_dat[31:24] : bl_q;
    mask_d = (wr && i_wb_adr == uart_rx_pkg::ADDR_IRQ_MASK && i_wb_sel[0]) ? i_wb_dat[3:0] : mask_q;
  end
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      adr_q  <= 12'h000;
      rd_q   <= 1'b0;
      node_q <= uart_rx_pkg::RST_NODE;
      bh_q   <= uart_rx_pkg::RST_BAUD_HIGH;
      bl_q   <= uart_rx_pkg::RST_BAUD_LOW;
      mask_q <= uart_rx_pkg::RST_IRQ_MASK;
    end
    else
    begin
      adr_q  <= adr_d;
      rd_q   <= rd_d;
      node_q <= node_d;
      bh_q   <= bh_d;
      bl_q   <= bl_d;
      mask_q <= mask_d;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  property p_ack_pulse;
    o_wb_ack |=> !o_wb_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_answer;
    take |=> o_wb_ack;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("request not answered next cycle");
  property p_ack_cause;
    o_wb_ack |-> $past(take);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without a request");
  property p_unmapped_zero;
    o_wb_ack && rd_q && adr_q[11:8] != 4'hf |-> o_wb_dat == 32'h0;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
  property p_irq_masked;
    mask_q == 4'h0 |-> !o_irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("interrupt with all masked");
  property p_irq_sticky;
    o_irq && !wr |=> o_irq;
  endproperty
  a_irq_sticky: assert property (p_irq_sticky) else $error("interrupt dropped unasked");
  property p_node_read;
    o_wb_ack && rd_q && adr_q == uart_rx_pkg::ADDR_NODE |-> o_wb_dat[15:8] == node_q;
  endproperty
  a_node_read: assert property (p_node_read) else $error("node address readback wrong");
  property p_high_read;
    o_wb_ack && rd_q && adr_q == uart_rx_pkg::ADDR_BAUD_HIGH |-> o_wb_dat[23:16] == bh_q;
  endproperty
  a_high_read: assert property (p_high_read) else $error("divisor high byte wrong");
  property p_low_read;
    o_wb_ack && rd_q && adr_q == uart_rx_pkg::ADDR_BAUD_LOW |-> o_wb_dat[31:24] == bl_q;
  endproperty
  a_low_read: assert property (p_low_read) else $error("divisor low byte wrong");
endmodule

bind uart_rx_core uart_rx_core_asserts u_chk
(
  .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
  .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
  .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_rx_line(i_rx_line), .o_irq(o_irq)
);

// ===== dv/serial_node_model.sv
// Remote serial node that frames characters onto the receive line
`timescale 1ns/1ps
module serial_node_model
(
  // Clock
  input  wire logic i_ref_clk,
  // Serial line, idle high between frames
  output logic      o_rx_line
);
  initial o_rx_line = 1'b1;
  // Start, eight data bits LSB first, optional address marker, stop
  task automatic send_char(input logic [7:0] val, input logic mp, input logic mark,
                           input logic stop, input int clks);
    logic [10:0] frame;
    frame = mp ? {stop, mark, val, 1'b0} : {1'b1, stop, val, 1'b0};
    for (int k = 0; k < (mp ? 11 : 10); k++)
    begin
      o_rx_line <= frame[k];
      repeat (clks) @(posedge i_ref_clk);
    end
    // One idle bit so a low stop still lets the next start be seen
    o_rx_line <= 1'b1;
    repeat (clks) @(posedge i_ref_clk);
  endtask
endmodule

// ===== dv/uart_receiver_error_addr_baud_test.sv
// Self-checking bench for the serial receiver
`timescale 1ns/1ps
module uart_receiver_error_addr_baud_test;
  logic        ref_clk, sys_rst, wb_cyc, wb_stb, wb_we, rx_line, wb_ack, irq;
  logic [11:0] wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_wdat, wb_rdat, rdat_full;
  logic [7:0]  r, v, b1;
  int          i, seed, miscompares, num_checks, bclk;

  uart_rx_core dut
  (
    .i_ref_clk(ref_clk), .i_sys_rst(sys_rst), .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb),
    .i_wb_we(wb_we), .i_wb_adr(wb_adr), .i_wb_sel(wb_sel), .i_wb_dat(wb_wdat),
    .o_wb_dat(wb_rdat), .o_wb_ack(wb_ack), .i_rx_line(rx_line), .o_irq(irq)
  );
  serial_node_model node
  (
    .i_ref_clk(ref_clk),
    .o_rx_line(rx_line)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  function automatic logic [7:0] st(input logic a, input logic o, input logic b);
    st = 8'h0;
    st[uart_rx_pkg::ST_DATA_AVAIL] = a;
    st[uart_rx_pkg::ST_OVERRUN]    = o;
    st[uart_rx_pkg::ST_BREAK]      = b;
  endfunction
  // Classic single cycle; the byte registers sit in their own lanes
  task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d);
    logic [1:0] ln;
    int         t;
    ln = (a >= uart_rx_pkg::ADDR_NODE && a <= uart_rx_pkg::ADDR_BAUD_LOW) ? a[1:0] : 2'h0;
    @(posedge ref_clk);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= w;
    wb_adr  <= a;
    wb_sel  <= 4'h1 << ln;
    wb_wdat <= {24'h0, d} << (8 * ln);
    t = 0;
    // Ack and read data are taken at the rising edge that shows ack high
    do
    begin
      @(posedge ref_clk);
      t++;
    end
    while (wb_ack !== 1'b1 && t < 20);
    check(wb_ack, 1'b1);
    r = wb_rdat[8 * ln +: 8];
    rdat_full = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask
  task automatic tx(input logic [7:0] d, input logic mp, input logic mk, input logic sp);
    node.send_char(d, mp, mk, sp, bclk);
  endtask
  task automatic irq_is(input logic e);
    @(negedge ref_clk);
    check(irq, e);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial
  begin
    repeat (40000) @(posedge ref_clk);
    miscompares++;
    summarize();
  end
  initial
  begin
    {seed, miscompares, num_checks, bclk} = {32'd75, 32'd0, 32'd0, 32'd16};
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_wdat} = '0;
    sys_rst = 1'b1;
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    wb(0, uart_rx_pkg::ADDR_NODE, 8'h00);
    check(r, 8'h00);
    wb(0, uart_rx_pkg::ADDR_BAUD_HIGH, 8'h00);
    check(r, 8'hff);
    wb(0, uart_rx_pkg::ADDR_BAUD_LOW, 8'h00);
    check(r, 8'hff);
    wb(0, 12'h100, 8'h00);
    check(rdat_full, 32'h0);
    for (i = 0; i < 9; i++)
    begin
      v = 8'($random(seed));
      wb(1, uart_rx_pkg::ADDR_NODE + 12'(i % 3), v);
      wb(1, 12'h100, ~v);
      wb(0, uart_rx_pkg::ADDR_NODE + 12'(i % 3), 8'h00);
      check(r, v);
    end
    $display("test registers done");
    wb(1, uart_rx_pkg::ADDR_CTRL, 8'h01);
    wb(1, uart_rx_pkg::ADDR_IRQ_MASK, 8'h01);
    wb(1, uart_rx_pkg::ADDR_BAUD_HIGH, 8'h00);
    for (i = 1; i < 3; i++)
    begin
      wb(1, uart_rx_pkg::ADDR_BAUD_LOW, 8'(i));
      bclk = 16 * i;
      v = 8'($random(seed));
      irq_is(1'b0);
      tx(v, 0, 0, 1);
      irq_is(1'b1);
      wb(0, uart_rx_pkg::ADDR_DATA, 8'h00);
      check(r, v);
      wb(0, uart_rx_pkg::ADDR_DATA, 8'h00);
      check(r, v);
      wb(1, uart_rx_pkg::ADDR_IRQ_STAT, 8'h0f);
      irq_is(1'b0);
    end
    $display("test receive done");
    wb(1, uart_rx_pkg::ADDR_IRQ_MASK, 8'h08);
    tx(8'($random(seed)), 0, 0, 1);
    irq_is(1'b0);
    wb(0, uart_rx_pkg::ADDR_DATA, 8'h00);
    tx(8'h5a, 0, 0, 0);
    irq_is(1'b1);
    wb(0, uart_rx_pkg::ADDR_STATUS, 8'h00);
    check(r[uart_rx_pkg::ST_FRAMING], 1'b1);
    wb(0, uart_rx_pkg::ADDR_DATA, 8'h00);
    wb(0, uart_rx_pkg::ADDR_DATA, 8'h00);
    wb(1, uart_rx_pkg::ADDR_IRQ_STAT, 8'h0f);
    wb(1, uart_rx_pkg::ADDR_IRQ_MASK, 8'h04);
    $display("test masking done");
    // Second character lands before the first is read: overrun, plain and by break
    for (i = 0; i < 2; i++)
    begin
      b1 = 8'($random(seed));
      tx(b1, 0, 0, 1);
      tx(i ? 8'h00 : 8'($random(seed)), 0, 0, !i);
      wb(0, uart_rx_pkg::ADDR_STATUS, 8'h00);
      check(r & st(1, 1, 1), st(1, 0, 0));
      wb(0, uart_rx_pkg::ADDR_DATA, 8'h00);
      check(r, b1);
      wb(0, uart_rx_pkg::ADDR_STATUS, 8'h00);
      check(r & st(1, 1, 1), st(1, 1, i[0]));
      irq_is(1'b1);
      wb(0, uart_rx_pkg::ADDR_DATA, 8'h00);
      wb(0, uart_rx_pkg::ADDR_STATUS, 8'h00);
      check(r & st(1, 1, 1), st(0, 0, 0));
      wb(1, uart_rx_pkg::ADDR_IRQ_STAT, 8'h0f);
    end
    $display("test overrun done");
    v = 8'($random(seed));
    wb(1, uart_rx_pkg::ADDR_NODE, v);
    wb(1, uart_rx_pkg::ADDR_IRQ_MASK, 8'h01);
    wb(1, uart_rx_pkg::ADDR_CTRL, 8'h0b);
    tx(v ^ 8'h01, 1, 1, 1);
    tx(8'($random(seed)), 1, 0, 1);
    wb(0, uart_rx_pkg::ADDR_STATUS, 8'h00);
    check(r & st(1, 0, 0), st(0, 0, 0));
    irq_is(1'b0);
    tx(v, 1, 1, 1);
    irq_is(1'b1);
    wb(0, uart_rx_pkg::ADDR_STATUS, 8'h00);
    check(r[uart_rx_pkg::ST_ADDR_BYTE], 1'b1);
    wb(0, uart_rx_pkg::ADDR_DATA, 8'h00);
    check(r, v);
    b1 = 8'($random(seed));
    tx(b1, 1, 0, 1);
    wb(0, uart_rx_pkg::ADDR_DATA, 8'h00);
    check(r, b1);
    // Multiprocessor on without compare: any address byte is taken
    wb(1, uart_rx_pkg::ADDR_CTRL, 8'h03);
    tx(~v, 1, 1, 1);
    wb(0, uart_rx_pkg::ADDR_DATA, 8'h00);
    check(r, 8'(~v));
    $display("test address filter done");
    summarize();
  end
endmodule
